// ### logic/dsspt_pkg.sv
/*
  Shared constants for the dual-slope symmetric PWM timer: byte map of the
  16-bit registers, mode and action codes, prescaler ratios, flag positions
  and the controller's own APB register map.
  Assumes a single 10 MHz clock shared by both ends.
*/
package dsspt_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;

  // Byte addresses on the 8-bit timer bus
  localparam logic [2:0] BA_CNT_L = 3'h0;
  localparam logic [2:0] BA_CNT_H = 3'h1;
  localparam logic [2:0] BA_CMP_A_L = 3'h2;
  localparam logic [2:0] BA_CMP_A_H = 3'h3;
  localparam logic [2:0] BA_CMP_B_L = 3'h4;
  localparam logic [2:0] BA_CMP_B_H = 3'h5;
  localparam logic [2:0] BA_CAP_L = 3'h6;
  localparam logic [2:0] BA_CAP_H = 3'h7;

  localparam logic [3:0] WAVE_TOP_CAPTURE = 4'h8;
  localparam logic [3:0] WAVE_TOP_CMP_A = 4'h9;

  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_NONINV = 2'h2;
  localparam logic [1:0] ACT_INV = 2'h3;

  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam int unsigned PRE_W = 10;
  localparam logic [PRE_W-1:0] PRE_END8 = 10'h007;
  localparam logic [PRE_W-1:0] PRE_END64 = 10'h03F;
  localparam logic [PRE_W-1:0] PRE_END256 = 10'h0FF;
  localparam logic [PRE_W-1:0] PRE_END1024 = 10'h3FF;

  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [15:0] TOP_MIN = 16'h0003;
  localparam logic [15:0] RST_VAL16 = 16'h0000;

  localparam int unsigned FLAG_W = 4;
  localparam int unsigned FLAG_OVF = 0;
  localparam int unsigned FLAG_CAP = 1;
  localparam int unsigned FLAG_MATCH_A = 2;

  // Controller APB map
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_CMD = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam int unsigned CTRL_WAVE_LSB = 0;
  localparam int unsigned CTRL_ACT_A_LSB = 4;
  localparam int unsigned CTRL_ACT_B_LSB = 6;
  localparam int unsigned CTRL_CS_LSB = 8;
  localparam int unsigned CTRL_DIR_LSB = 11;
  localparam int unsigned CMD_DATA_LSB = 0;
  localparam int unsigned CMD_ADDR_LSB = 8;
  localparam int unsigned CMD_READ_BIT = 16;
  localparam int unsigned STAT_DATA_LSB = 0;
  localparam int unsigned STAT_BUSY_BIT = 8;
  localparam int unsigned STAT_FLAG_LSB = 16;

  typedef enum logic {DSSPT_UP = 1'b0, DSSPT_DOWN = 1'b1} dsspt_dir_t;
endpackage : dsspt_pkg

// ### logic/dsspt_if.sv
/*
  Carrier between the timer and its controller: 8-bit byte bus with
  one-cycle read and write strobes, control levels and flag lines.
  Assumes both ends share pclk.
*/
`timescale 1ns/10ps
interface dsspt_if;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic [3:0] wave_shape_select;
  logic [1:0] output_action_a;
  logic [1:0] output_action_b;
  logic [2:0] clock_select;
  logic [1:0] output_pin_direction;
  logic [3:0] flags;
  logic [3:0] flag_clear;

  modport dev (input addr, wdata, wr, rd, wave_shape_select, output_action_a, output_action_b,
    clock_select, output_pin_direction, flag_clear, output rdata, flags);
  modport host (output addr, wdata, wr, rd, wave_shape_select, output_action_a, output_action_b,
    clock_select, output_pin_direction, flag_clear, input rdata, flags);
endinterface : dsspt_if

// ### logic/dsspt_timer.sv
/*
  16-bit dual-slope symmetric PWM timer with two compare channels, a
  prescaler and the shared high-byte access path.
  Assumes a controller on the host modport issuing one-cycle byte strobes.
*/
`timescale 1ns/10ps
module dsspt_timer
  import dsspt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  dsspt_if.dev bus,
  output logic [1:0] compare_output,
  output logic [1:0] compare_output_oe_n
);
  import dsspt_pkg::*;

  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [15:0] count_value;
    dsspt_dir_t dir;
    logic [15:0] cmp_a;
    logic [15:0] cmp_a_buf;
    logic [15:0] cmp_b;
    logic [15:0] cmp_b_buf;
    logic [15:0] capture_top_value;
    logic [7:0] temp_high;
    logic [7:0] rdata;
    logic [FLAG_W-1:0] flags;
    logic [1:0] oc;
  } dsspt_tmr_t;

  dsspt_tmr_t st_r;
  dsspt_tmr_t st_nxt;
  logic timer_tick;
  logic mode_on;
  logic [15:0] top;
  logic at_top;
  logic at_bottom;
  logic up_phase;
  logic [15:0] cmp_val [2];
  logic [1:0] act [2];
  logic [1:0] connected;
  logic [1:0] hit;

  assign mode_on = (bus.wave_shape_select == WAVE_TOP_CAPTURE) || (bus.wave_shape_select == WAVE_TOP_CMP_A);
  assign top = (bus.wave_shape_select == WAVE_TOP_CAPTURE) ? st_r.capture_top_value : st_r.cmp_a;
  assign at_top = (st_r.count_value == top);
  assign at_bottom = (st_r.count_value == BOTTOM);
  // BOTTOM counts as rising and TOP as falling, so extreme compare values give steady levels
  assign up_phase = at_bottom || ((st_r.dir == DSSPT_UP) && !at_top);
  assign cmp_val[0] = st_r.cmp_a;
  assign cmp_val[1] = st_r.cmp_b;
  assign act[0] = bus.output_action_a;
  assign act[1] = bus.output_action_b;

  // Prescaler tick: one pclk-wide enable, never a clock of its own
  always_comb begin
    unique case (bus.clock_select)
      CS_DIV1: timer_tick = 1'b1;
      CS_DIV8: timer_tick = ((st_r.pre & PRE_END8) == PRE_END8);
      CS_DIV64: timer_tick = ((st_r.pre & PRE_END64) == PRE_END64);
      CS_DIV256: timer_tick = ((st_r.pre & PRE_END256) == PRE_END256);
      CS_DIV1024: timer_tick = (st_r.pre == PRE_END1024);
      // Codes 6 and 7 hold the count, as stop does
      default: timer_tick = 1'b0;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    // Prescaler runs free except in stop, which holds it; its phase is kept when the ratio changes
    st_nxt.pre = (bus.clock_select == CS_STOP) ? st_r.pre : st_r.pre + 10'h001;
    // Clear first so that a flag set in the same cycle survives
    st_nxt.flags = st_r.flags & ~bus.flag_clear;

    if (timer_tick && mode_on) begin
      if (at_bottom) begin
        st_nxt.cmp_a = st_r.cmp_a_buf;
        st_nxt.cmp_b = st_r.cmp_b_buf;
        st_nxt.flags[FLAG_OVF] = 1'b1;
        st_nxt.count_value = st_r.count_value + 16'h0001;
        st_nxt.dir = DSSPT_UP;
      end else if (at_top && (st_r.dir == DSSPT_UP)) begin
        // TOP has lasted this one tick; turn round
        st_nxt.count_value = st_r.count_value - 16'h0001;
        st_nxt.dir = DSSPT_DOWN;
        if (bus.wave_shape_select == WAVE_TOP_CAPTURE) begin
          st_nxt.flags[FLAG_CAP] = 1'b1;
        end else begin
          st_nxt.flags[FLAG_MATCH_A] = 1'b1;
        end
      end else if (st_r.dir == DSSPT_UP) begin
        // A TOP lowered under the count runs on to wrap, as the hardware would
        st_nxt.count_value = st_r.count_value + 16'h0001;
      end else begin
        st_nxt.count_value = st_r.count_value - 16'h0001;
      end

      for (int i = 0; i < 2; i++) begin
        // Only equality matches: a compare above TOP is never reached
        if (hit[i]) begin
          st_nxt.flags[FLAG_MATCH_A + i] = 1'b1;
          unique case (act[i])
            ACT_NONINV: st_nxt.oc[i] = !up_phase;
            ACT_INV: st_nxt.oc[i] = up_phase;
            ACT_TOGGLE: begin
              if ((i == 0) && bus.wave_shape_select[3]) begin
                st_nxt.oc[i] = !st_r.oc[i];
              end
            end
            ACT_OFF: begin
            end
          endcase
        end
      end
    end

    // Reads take st_r, so a tick in the same cycle cannot split a pair
    // Compare reads show the buffer, the value software last wrote
    if (bus.rd) begin
      unique case (bus.addr)
        BA_CNT_L: begin
          st_nxt.rdata = st_r.count_value[7:0];
          st_nxt.temp_high = st_r.count_value[15:8];
        end
        BA_CAP_L: begin
          st_nxt.rdata = st_r.capture_top_value[7:0];
          st_nxt.temp_high = st_r.capture_top_value[15:8];
        end
        BA_CNT_H: st_nxt.rdata = st_r.temp_high;
        BA_CAP_H: st_nxt.rdata = st_r.temp_high;
        BA_CMP_A_L: st_nxt.rdata = st_r.cmp_a_buf[7:0];
        BA_CMP_A_H: st_nxt.rdata = st_r.cmp_a_buf[15:8];
        BA_CMP_B_L: st_nxt.rdata = st_r.cmp_b_buf[7:0];
        BA_CMP_B_H: st_nxt.rdata = st_r.cmp_b_buf[15:8];
      endcase
    end

    // Software order (high then low) is assumed, not checked
    if (bus.wr) begin
      unique case (bus.addr)
        BA_CNT_H, BA_CMP_A_H, BA_CMP_B_H, BA_CAP_H: st_nxt.temp_high = bus.wdata;
        BA_CNT_L: st_nxt.count_value = {st_r.temp_high, bus.wdata};
        BA_CMP_A_L: begin
          st_nxt.cmp_a_buf = {st_r.temp_high, bus.wdata};
          // Outside modes 8 and 9 the active copy follows at once
          if (!mode_on) begin
            st_nxt.cmp_a = {st_r.temp_high, bus.wdata};
          end
        end
        BA_CMP_B_L: begin
          st_nxt.cmp_b_buf = {st_r.temp_high, bus.wdata};
          if (!mode_on) begin
            st_nxt.cmp_b = {st_r.temp_high, bus.wdata};
          end
        end
        BA_CAP_L: st_nxt.capture_top_value = {st_r.temp_high, bus.wdata};
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign connected[0] = (act[0] != ACT_OFF) && ((act[0] != ACT_TOGGLE) || bus.wave_shape_select[3]);
  // Channel B has no toggle action, so action 1 leaves its pin free
  assign connected[1] = (act[1] == ACT_NONINV) || (act[1] == ACT_INV);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      assign compare_output[g] = st_r.oc[g];
      assign hit[g] = (st_r.count_value == cmp_val[g]);
      assign compare_output_oe_n[g] = !(connected[g] && bus.output_pin_direction[g]);
    end
  endgenerate

  assign bus.rdata = st_r.rdata;
  assign bus.flags = st_r.flags;
endmodule : dsspt_timer

// ### logic/dsspt_host.sv
/*
  Controller end: an APB slave that holds the timer's control levels,
  turns command writes into single byte strobes and reports read bytes
  and flags. Assumes a zero-wait APB master on pclk.
*/
`timescale 1ns/10ps
module dsspt_host
  import dsspt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  dsspt_if.host bus
);
  import dsspt_pkg::*;

  typedef struct packed {
    logic [12:0] ctrl;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic rd_pend;
    logic [7:0] rbyte;
    logic [FLAG_W-1:0] flag_clear;
    logic [31:0] prdata;
  } dsspt_host_t;

  dsspt_host_t st_r;
  dsspt_host_t st_nxt;
  logic wr_acc;

  assign wr_acc = psel && penable && pwrite;

  always_comb begin
    st_nxt = st_r;
    st_nxt.wr = 1'b0;
    st_nxt.rd = 1'b0;
    st_nxt.flag_clear = '0;
    st_nxt.rd_pend = st_r.rd;
    // Device answers a read strobe one cycle later
    if (st_r.rd_pend) begin
      st_nxt.rbyte = bus.rdata;
    end
    // Read data is picked in the setup cycle so it leaves a flop with no wait state
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        OFS_CTRL: st_nxt.prdata = {19'h00000, st_r.ctrl};
        OFS_STATUS: st_nxt.prdata = {12'h000, bus.flags, 7'h00, (st_r.rd || st_r.rd_pend), st_r.rbyte};
        default: st_nxt.prdata = 32'h00000000;
      endcase
    end
    // Each command is one byte access; software keeps byte order and atomicity
    if (wr_acc) begin
      unique case (paddr)
        OFS_CTRL: st_nxt.ctrl = pwdata[12:0];
        OFS_CMD: begin
          st_nxt.addr = pwdata[CMD_ADDR_LSB +: 3];
          st_nxt.wdata = pwdata[CMD_DATA_LSB +: 8];
          st_nxt.rd = pwdata[CMD_READ_BIT];
          st_nxt.wr = !pwdata[CMD_READ_BIT];
        end
        OFS_STATUS: st_nxt.flag_clear = pwdata[STAT_FLAG_LSB +: FLAG_W];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.prdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign bus.addr = st_r.addr;
  assign bus.wdata = st_r.wdata;
  assign bus.wr = st_r.wr;
  assign bus.rd = st_r.rd;
  assign bus.flag_clear = st_r.flag_clear;
  assign bus.wave_shape_select = st_r.ctrl[CTRL_WAVE_LSB +: 4];
  assign bus.output_action_a = st_r.ctrl[CTRL_ACT_A_LSB +: 2];
  assign bus.output_action_b = st_r.ctrl[CTRL_ACT_B_LSB +: 2];
  assign bus.clock_select = st_r.ctrl[CTRL_CS_LSB +: 3];
  assign bus.output_pin_direction = st_r.ctrl[CTRL_DIR_LSB +: 2];
endmodule : dsspt_host

// ### verification/dsspt_props.sv
/*
  Checker on the carrier between timer and controller: strobes, read byte,
  sticky flags and their causes.
  Assumes it is instantiated in the bench beside the carrier, on pclk.
*/
`timescale 1ns/10ps
module dsspt_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [3:0] wave_shape_select,
  input wire logic [2:0] clock_select,
  input wire logic [3:0] flags,
  input wire logic [3:0] flag_clear
);
  import dsspt_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_no_read;
    !rd ##1 1'b1;
  endsequence
  sequence s_ovf_rise;
    $rose(flags[FLAG_OVF]);
  endsequence
  chk_one_strobe: assert property (!(wr && rd))
    else $error("read and write strobes together");
  chk_rd_single: assert property (rd |=> !rd)
    else $error("read strobe longer than one cycle");
  chk_wr_single: assert property (wr |=> !wr)
    else $error("write strobe longer than one cycle");
  chk_rdata_held: assert property (s_no_read |-> $stable(rdata))
    else $error("read byte changed without a read");
  // A flag only falls when the controller asked for it
  chk_flags_sticky: assert property ((($past(flags) & ~$past(flag_clear)) & ~flags) == 4'h0)
    else $error("flag lost without clear");
  chk_cap_mode: assert property ($rose(flags[FLAG_CAP]) |-> $past(wave_shape_select) == WAVE_TOP_CAPTURE)
    else $error("capture flag outside capture top mode");
  // Two cycles of slack: the tick may be decoded from the previous select
  chk_no_tick_stop: assert property (s_ovf_rise |-> ($past(clock_select) != CS_STOP
    || $past(clock_select, 2) != CS_STOP))
    else $error("overflow while prescaler stopped");
  chk_ovf_top_gap: assert property (s_ovf_rise |=> (!$rose(flags[FLAG_CAP]))[*2])
    else $error("top flag too soon after bottom");
endmodule : dsspt_props

// ### verification/testbench.sv
/*
  Bench joining timer and controller over the carrier; drives APB, checks
  byte access, PWM levels, flags and pin enables.
  Assumes the dsspt design files and package.
*/
`timescale 1ns/10ps
module testbench;
  import dsspt_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rv;
  logic pready;
  logic pslverr;
  logic slverr_seen;
  logic [1:0] cmp_out;
  logic [1:0] oe_n;
  int bad_count = 0;
  int n_tests = 0;
  dsspt_if link();
  dsspt_timer dsspt_timer_inst(.pclk(pclk), .presetn(presetn), .bus(link.dev), .compare_output(cmp_out),
    .compare_output_oe_n(oe_n));
  dsspt_host dsspt_host_inst(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(link.host));
  dsspt_props dsspt_props_inst(.pclk(pclk), .presetn(presetn), .wr(link.wr), .rd(link.rd), .rdata(link.rdata),
    .wave_shape_select(link.wave_shape_select), .clock_select(link.clock_select), .flags(link.flags),
    .flag_clear(link.flag_clear));
  always #50 pclk = ~pclk;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done
  // Zero-wait slave, but the wait is still bounded rather than assumed
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      test_done();
    end
    rv = prdata;
    slverr_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic bw(input logic [2:0] a, input logic [7:0] d);
    apb(1'b1, OFS_CMD, {21'h0, a, d});
  endtask : bw
  task automatic br(input logic [2:0] a, output logic [7:0] d);
    int n;
    n = 0;
    apb(1'b1, OFS_CMD, {15'h0, 1'b1, 5'h0, a, 8'h00});
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rv[STAT_BUSY_BIT] !== 1'b0 && n < 20);
    check("busy", 32'(rv[STAT_BUSY_BIT]), 32'h0);
    d = rv[7:0];
  endtask : br
  task automatic w16(input logic [2:0] lo, input logic [15:0] v);
    bw(lo + 3'h1, v[15:8]);
    bw(lo, v[7:0]);
  endtask : w16
  task automatic r16(input logic [2:0] lo, output logic [15:0] v);
    br(lo, v[7:0]);
    br(lo + 3'h1, v[15:8]);
  endtask : r16
  task automatic setc(input logic [3:0] m, input logic [1:0] aa, ab, input logic [2:0] cs);
    apb(1'b1, OFS_CTRL, {19'h0, 2'b11, cs, ab, aa, m});
  endtask : setc
  task automatic chk_oe(input logic [1:0] e);
    @(negedge pclk);
    check("oe_n", 32'(oe_n), 32'(e));
  endtask : chk_oe
  // Sums stay logic so that an unknown level cannot pass as zero
  task automatic count_hi(input int win, output logic [31:0] ha, output logic [31:0] hb);
    ha = 32'h0;
    hb = 32'h0;
    repeat (win) @(posedge pclk);
    repeat (win) begin
      @(negedge pclk);
      ha += cmp_out[0];
      hb += cmp_out[1];
    end
  endtask : count_hi
  // Two whole periods are counted, so the phase at the start does not matter
  task automatic run(input logic [3:0] m, input logic [2:0] cs, input int nd, input logic [15:0] top,
    input logic [15:0] ca, input logic [15:0] cb);
    logic [31:0] ha;
    logic [31:0] hb;
    int win;
    logic [3:0] ef;
    win = 4 * nd * top;
    setc(4'h0, ACT_NONINV, ACT_INV, CS_STOP);
    w16(BA_CNT_L, 16'h0000);
    w16(BA_CAP_L, top);
    w16(BA_CMP_A_L, ca);
    w16(BA_CMP_B_L, cb);
    setc(m, ACT_NONINV, ACT_INV, cs);
    chk_oe(2'b00);
    count_hi(win, ha, hb);
    check("high_a", ha, 4 * nd * ca);
    if (cb <= top) check("high_b", hb, 4 * nd * (top - cb));
    setc(m, ACT_NONINV, ACT_INV, CS_STOP);
    apb(1'b0, OFS_STATUS, 32'h0);
    ef = {cb <= top, ca <= top, m == WAVE_TOP_CAPTURE, 1'b1};
    check("flags", 32'(rv[19:16]), 32'(ef));
    apb(1'b1, OFS_STATUS, 32'h000F0000);
    apb(1'b0, OFS_STATUS, 32'h0);
    check("flags_clr", 32'(rv[19:16]), 32'h0);
    $display("pwm run mode %0d top %0d done", m, top);
  endtask : run
  initial begin
    logic [15:0] v;
    logic [7:0] b;
    logic [31:0] ha;
    logic [31:0] hb;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    chk_oe(2'b11);
    apb(1'b0, OFS_CTRL, 32'h0);
    check("ctrl", rv, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    check("unmapped", rv, 32'h0);
    check("pslverr", 32'(slverr_seen), 32'h0);
    $display("reset test done");
    setc(4'h0, ACT_OFF, ACT_OFF, CS_STOP);
    w16(BA_CNT_L, 16'h01FF);
    r16(BA_CNT_L, v);
    check("cnt", 32'(v), 32'h01FF);
    bw(BA_CNT_H, 8'h5A);
    bw(BA_CAP_L, 8'h34);
    r16(BA_CAP_L, v);
    check("cap", 32'(v), 32'h5A34);
    w16(BA_CMP_A_L, 16'hC3A5);
    br(BA_CNT_L, b);
    br(BA_CMP_A_H, b);
    check("cmpa_h", 32'(b), 32'hC3);
    br(BA_CAP_H, b);
    check("temp", 32'(b), 32'h01);
    $display("byte access test done");
    run(WAVE_TOP_CAPTURE, CS_DIV1, 1, 16'h0003, 16'h0001, 16'h0002);
    run(WAVE_TOP_CAPTURE, CS_DIV8, 8, 16'h0005, 16'h0000, 16'h0005);
    run(WAVE_TOP_CMP_A, CS_DIV64, 64, 16'h0004, 16'h0004, 16'h0001);
    run(WAVE_TOP_CAPTURE, CS_DIV256, 256, 16'h0003, 16'h0002, 16'h0007);
    run(WAVE_TOP_CMP_A, CS_DIV1024, 1024, 16'h0003, 16'h0003, 16'h0000);
    setc(WAVE_TOP_CAPTURE, ACT_TOGGLE, ACT_TOGGLE, CS_STOP);
    chk_oe(2'b10);
    setc(4'h1, ACT_TOGGLE, ACT_OFF, CS_STOP);
    chk_oe(2'b11);
    // One toggle per period at TOP: high for exactly half of two periods
    w16(BA_CNT_L, 16'h0000);
    w16(BA_CMP_A_L, 16'h0003);
    setc(WAVE_TOP_CMP_A, ACT_TOGGLE, ACT_OFF, CS_DIV1);
    count_hi(12, ha, hb);
    check("toggle_a", ha, 32'h6);
    $display("pin enable and toggle test done");
    test_done();
  end
endmodule : testbench
